// ---- src/ppt_pkg.sv ----
// Package for the parallel port block: register map, widths and pin carriers
package ppt_pkg;
   localparam int PPT_ADDR_W = 4;
   localparam logic [3:0] PPT_OFF_B_DATA = 4'h1;
   localparam logic [3:0] PPT_OFF_C_DATA = 4'h2;
   localparam logic [3:0] PPT_OFF_D_DATA = 4'h3;
   localparam logic [3:0] PPT_OFF_B_DIR = 4'h5;
   localparam logic [3:0] PPT_OFF_C_DIR = 4'h6;
   localparam logic [3:0] PPT_OFF_D_DIR = 4'h7;
   localparam logic [3:0] PPT_OFF_C_PULL = 4'h8;
   localparam logic [3:0] PPT_OFF_D_PULL = 4'h9;
   localparam logic [7:0] PPT_DIR_RESET = 8'h00;
   localparam logic [7:0] PPT_PULL_RESET = 8'h00;
   localparam logic [7:0] PPT_READ_NONE = 8'h00;
   localparam int PPT_SS_BIT = 0;
   localparam int PPT_SPI_LO = 0;
   localparam int PPT_SPI_HI = 3;
   localparam int PPT_T1_CH0_BIT = 4;
   localparam int PPT_T2_CH0_BIT = 6;
   localparam logic [1:0] PPT_ELS_GPIO = 2'b00;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ppt_bus_s;

   // Three signals of one port's pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull;
   } ppt_pin_drv_s;

   // Pin overrides from the shared peripherals of port D
   typedef struct packed {
      logic serial_periph_enable;
      logic serial_periph_master;
      logic [3:0] spi_out;
      logic [3:0] spi_oe;
      logic [1:0] first_timer_els0;
      logic [1:0] first_timer_els1;
      logic [1:0] second_timer_els0;
      logic [1:0] second_timer_els1;
      logic [3:0] timer_out;
      logic [3:0] timer_oe;
   } ppt_share_s;
endpackage

// ---- src/ppt_ports.sv ----
// Parallel ports B, C and D with direction, pullup and shared pin logic
module ppt_ports #(
   parameter int B_W = 8,
   parameter int C_W = 7,
   parameter int D_W = 8
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ppt_pkg::ppt_bus_s bus,
   output logic [7:0] rdata,
   input wire logic [7:0] port_b_pin_in,
   input wire logic [7:0] port_c_pin_in,
   input wire logic [7:0] port_d_pin_in,
   input wire logic converter_enable,
   input wire logic [2:0] converter_channel_select,
   output logic [7:0] analog_select,
   input wire ppt_pkg::ppt_share_s share,
   output ppt_pkg::ppt_pin_drv_s port_b_drv,
   output ppt_pkg::ppt_pin_drv_s port_c_drv,
   output ppt_pkg::ppt_pin_drv_s port_d_drv
);
   import ppt_pkg::*;

   logic [7:0] port_b_latch;
   logic [7:0] port_c_latch;
   logic [7:0] port_d_latch;
   logic [7:0] port_b_dir;
   logic [7:0] port_c_dir;
   logic [7:0] port_d_dir;
   logic [7:0] port_c_pull_en;
   logic [7:0] port_d_pull_en;
   logic [7:0] mask_b;
   logic [7:0] mask_c;
   logic [7:0] mask_d;
   logic [23:0] sync_a;
   logic [23:0] sync_b;
   logic [7:0] pin_b;
   logic [7:0] pin_c;
   logic [7:0] pin_d;
   logic [7:0] next_rdata;
   wire logic [7:0] d_own;
   wire logic [7:0] d_out;
   wire logic [7:0] d_oe;
   wire logic [7:0] d_pin_out;
   wire logic [7:0] d_pin_oe_n;
   wire logic [7:0] d_pin_pull;
   wire logic [1:0] els [4];

   assign mask_b = 8'((1 << B_W) - 1);
   assign mask_c = 8'((1 << C_W) - 1);
   assign mask_d = 8'((1 << D_W) - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Data latches, no reset
   always_ff @(posedge ref_clk) begin
      if (bus.wr && bus.addr == PPT_OFF_B_DATA) begin
         port_b_latch <= bus.wdata & mask_b;
      end
      if (bus.wr && bus.addr == PPT_OFF_C_DATA) begin
         port_c_latch <= bus.wdata & mask_c;
      end
      if (bus.wr && bus.addr == PPT_OFF_D_DATA) begin
         port_d_latch <= bus.wdata & mask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direction and pullup registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         port_b_dir <= PPT_DIR_RESET;
         port_c_dir <= PPT_DIR_RESET;
         port_d_dir <= PPT_DIR_RESET;
         port_c_pull_en <= PPT_PULL_RESET;
         port_d_pull_en <= PPT_PULL_RESET;
      end else if (bus.wr) begin
         unique case (bus.addr)
            PPT_OFF_B_DIR: port_b_dir <= bus.wdata & mask_b;
            PPT_OFF_C_DIR: port_c_dir <= bus.wdata & mask_c;
            PPT_OFF_D_DIR: port_d_dir <= bus.wdata & mask_d;
            PPT_OFF_C_PULL: port_c_pull_en <= bus.wdata & mask_c;
            PPT_OFF_D_PULL: port_d_pull_en <= bus.wdata & mask_d;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronizers
   always_ff @(posedge ref_clk) begin
      sync_a <= {port_d_pin_in, port_c_pin_in, port_b_pin_in};
      sync_b <= sync_a;
   end
   assign pin_b = sync_b[7:0];
   assign pin_c = sync_b[15:8];
   assign pin_d = sync_b[23:16];

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_comb begin
      next_rdata = PPT_READ_NONE;
      unique case (bus.addr)
         PPT_OFF_B_DATA: next_rdata = ((port_b_dir & port_b_latch)
                                       | (~port_b_dir & pin_b)) & mask_b;
         PPT_OFF_C_DATA: next_rdata = ((port_c_dir & port_c_latch)
                                       | (~port_c_dir & pin_c)) & mask_c;
         PPT_OFF_D_DATA: next_rdata = ((port_d_dir & port_d_latch)
                                       | (~port_d_dir & pin_d)) & mask_d;
         PPT_OFF_B_DIR: next_rdata = port_b_dir;
         PPT_OFF_C_DIR: next_rdata = port_c_dir;
         PPT_OFF_D_DIR: next_rdata = port_d_dir;
         PPT_OFF_C_PULL: next_rdata = port_c_pull_en;
         PPT_OFF_D_PULL: next_rdata = port_d_pull_en;
         default: next_rdata = PPT_READ_NONE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata <= PPT_READ_NONE;
      end else if (bus.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= PPT_READ_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter channel steering of port B
   always_comb begin
      analog_select = 8'h00;
      if (converter_enable) begin
         analog_select[converter_channel_select] = 1'b1;
      end
   end

   always_comb begin
      port_b_drv.out = port_b_latch;
      port_b_drv.oe_n = ~(port_b_dir & ~analog_select);
      port_b_drv.pull = 8'h00;
      port_c_drv.out = port_c_latch;
      port_c_drv.oe_n = ~port_c_dir;
      port_c_drv.pull = port_c_pull_en & ~port_c_dir;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port D pin sharing
   assign els[0] = share.first_timer_els0;
   assign els[1] = share.first_timer_els1;
   assign els[2] = share.second_timer_els0;
   assign els[3] = share.second_timer_els1;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pd
         if (gi <= PPT_SPI_HI) begin : g_spi
            // Slave select is only taken when enabled as a slave
            if (gi == PPT_SS_BIT) begin : g_ss
               assign d_own[gi] = share.serial_periph_enable
                                  && !share.serial_periph_master;
            end else begin : g_sd
               assign d_own[gi] = share.serial_periph_enable;
            end
            assign d_out[gi] = share.spi_out[gi - PPT_SPI_LO];
            assign d_oe[gi] = share.spi_oe[gi - PPT_SPI_LO];
         end else begin : g_tim
            // Channel function whenever its select field is not zero
            assign d_own[gi] = els[gi - PPT_T1_CH0_BIT] != PPT_ELS_GPIO;
            assign d_out[gi] = share.timer_out[gi - PPT_T1_CH0_BIT];
            assign d_oe[gi] = share.timer_oe[gi - PPT_T1_CH0_BIT];
         end
         assign d_pin_out[gi] = d_own[gi] ? d_out[gi] : port_d_latch[gi];
         assign d_pin_oe_n[gi] = d_own[gi] ? ~d_oe[gi] : ~port_d_dir[gi];
         assign d_pin_pull[gi] = port_d_pull_en[gi] && !port_d_dir[gi]
                                 && (!d_own[gi] || !d_oe[gi]);
      end
   endgenerate

   // Port D pin carrier
   assign port_d_drv = '{out: d_pin_out, oe_n: d_pin_oe_n, pull: d_pin_pull};
endmodule

// ---- testbench/ppt_props.sv ----
// Checker for the parallel port block
module ppt_props import ppt_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ppt_pkg::ppt_bus_s bus,
   input wire logic [7:0] rdata,
   input wire logic converter_enable,
   input wire logic [2:0] converter_channel_select,
   input wire logic [7:0] analog_select,
   input wire ppt_pkg::ppt_share_s share,
   input wire ppt_pkg::ppt_pin_drv_s port_b_drv,
   input wire ppt_pkg::ppt_pin_drv_s port_c_drv,
   input wire ppt_pkg::ppt_pin_drv_s port_d_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_rst_dir;
      $rose(nrst) |-> port_b_drv.oe_n == 8'hff && port_c_drv.oe_n[6:0] == 7'h7f;
   endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("dir not clear");
   property p_dir_rd;
      bus.rd && bus.addr == PPT_OFF_B_DIR && !converter_enable
         |=> rdata == ~$past(port_b_drv.oe_n);
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("dir readback");
   property p_dir_wr;
      bus.wr && bus.addr == PPT_OFF_B_DIR
         |=> converter_enable || port_b_drv.oe_n == ~$past(bus.wdata);
   endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("dir to buffer");
   property p_c_drive;
      bus.wr && bus.addr == PPT_OFF_C_DATA
         |=> ((port_c_drv.out ^ $past(bus.wdata)) & ~port_c_drv.oe_n & 8'h7f) == 8'h00;
   endproperty
   a_c_drive: assert property (p_c_drive) else $error("latch not driven");
   property p_c_pull;
      (port_c_drv.pull & ~port_c_drv.oe_n) == 8'h00;
   endproperty
   a_c_pull: assert property (p_c_pull) else $error("C pull on output");
   property p_d_pull;
      (port_d_drv.pull & ~port_d_drv.oe_n) == 8'h00;
   endproperty
   a_d_pull: assert property (p_d_pull) else $error("D pull on output");
   property p_analog;
      converter_enable |-> analog_select == 8'h01 << converter_channel_select
         && (analog_select & ~port_b_drv.oe_n) == 8'h00;
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin");
   property p_spi;
      share.serial_periph_enable |-> port_d_drv.oe_n[3:1] == ~share.spi_oe[3:1];
   endproperty
   a_spi: assert property (p_spi) else $error("serial pin dir");
   property p_tmr2;
      share.second_timer_els0 != PPT_ELS_GPIO |-> port_d_drv.oe_n[6] == !share.timer_oe[2];
   endproperty
   a_tmr2: assert property (p_tmr2) else $error("timer2 pin");
   property p_tmr1;
      share.first_timer_els0 != PPT_ELS_GPIO |-> port_d_drv.oe_n[4] == !share.timer_oe[0];
   endproperty
   a_tmr1: assert property (p_tmr1) else $error("timer1 pin");
   c_spi: cover property (share.serial_periph_enable && share.spi_oe != 4'h0);
   c_analog: cover property (converter_enable);
   c_rd: cover property (bus.rd && bus.addr == PPT_OFF_B_DATA);
endmodule
bind ppt_ports ppt_props u_props(.ref_clk, .nrst, .bus, .rdata, .converter_enable,
   .converter_channel_select, .analog_select, .share, .port_b_drv, .port_c_drv, .port_d_drv);

// ---- testbench/ppt_pins_model.sv ----
// Pads of ports B, C and D with external drivers
module ppt_pins_model (
   input wire logic ref_clk,
   input wire ppt_pkg::ppt_pin_drv_s drv [3],
   input wire logic [7:0] ext [3],
   input wire logic [7:0] flt [3],
   output logic [7:0] pin [3]
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog = 1'b0;
   always @(posedge ref_clk) tog <= !tog;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 8; j++) begin
            if (!drv[i].oe_n[j]) pin[i][j] = drv[i].out[j];
            else if (!flt[i][j]) pin[i][j] = ext[i][j];
            else pin[i][j] = drv[i].pull[j] | tog;
         end
      end
   end
endmodule

// ---- testbench/test_ppt_ports.sv ----
// Self-checking bench for the parallel port block
module test_ppt_ports import ppt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   ppt_bus_s bus = '0;
   logic [7:0] rdata;
   logic converter_enable = 1'b0;
   logic [2:0] converter_channel_select = 3'h0;
   logic [7:0] analog_select;
   ppt_share_s share = '0;
   ppt_pin_drv_s drv [3];
   logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] flt [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] pin [3];
   logic [3:0] regs [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
   logic [3:0] dat [3] = '{4'h1, 4'h2, 4'h3};
   logic [3:0] dir [3] = '{4'h5, 4'h6, 4'h7};
   logic [3:0] pul [3] = '{4'h0, 4'h8, 4'h9};
   logic [7:0] msk [3] = '{8'hff, 8'h7f, 8'hff};
   int n_fail = 0;
   int cmp_count = 0;
   always #4 ref_clk = !ref_clk;
   ppt_ports dut(.ref_clk, .nrst, .bus, .rdata, .port_b_pin_in(pin[0]),
      .port_c_pin_in(pin[1]), .port_d_pin_in(pin[2]), .converter_enable,
      .converter_channel_select, .analog_select, .share, .port_b_drv(drv[0]),
      .port_c_drv(drv[1]), .port_d_drv(drv[2]));
   ppt_pins_model pads(.ref_clk, .drv, .ext, .flt, .pin);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      repeat (4) @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      chk(drv[0].oe_n, 8'hff);
      chk(drv[1].oe_n | 8'h80, 8'hff);
      @(posedge ref_clk);
      ext[0] <= 8'ha5;
      wr(dat[0], 8'h5a);
      rd(dat[0], 8'ha5);
      wr(dir[0], 8'hf0);
      chk(drv[0].oe_n, 8'h0f);
      rd(dat[0], 8'h55);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(dir[0], 8'h00);
      wr(dir[0], 8'hff);
      rd(dat[0], 8'h5a);
      for (int i = 1; i < 3; i++) begin
         @(posedge ref_clk);
         flt[i] <= 8'hff;
         wr(dat[i], 8'h00);
         wr(pul[i], 8'hff);
         rd(dat[i], msk[i]);
         wr(dir[i], 8'h0f);
         chk(drv[i].pull & msk[i], msk[i] & 8'hf0);
         rd(dat[i], msk[i] & 8'hf0);
      end
      @(posedge ref_clk);
      share.serial_periph_enable <= 1'b1;
      share.spi_oe <= 4'b0110;
      share.spi_out <= 4'b0100;
      rd(dat[2], 8'hf0);
      chk(drv[2].oe_n & 8'h0e, 8'h08);
      chk(drv[2].out & 8'h06, 8'h04);
      chk(drv[2].oe_n & 8'h01, 8'h01);
      @(posedge ref_clk);
      share.serial_periph_master <= 1'b1;
      #1;
      chk(drv[2].oe_n & 8'h01, 8'h00);
      @(posedge ref_clk);
      share.serial_periph_enable <= 1'b0;
      share.second_timer_els0 <= 2'b01;
      share.first_timer_els0 <= 2'b10;
      share.timer_oe <= 4'b0100;
      wr(dir[2], 8'hd0);
      chk(drv[2].oe_n & 8'h50, 8'h10);
      @(posedge ref_clk);
      converter_enable <= 1'b1;
      converter_channel_select <= 3'h3;
      #1;
      chk(analog_select, 8'h08);
      chk(drv[0].oe_n & 8'h08, 8'h08);
      give_verdict();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      give_verdict();
   end
endmodule
